// *** rtl/hsw_host.sv ***
// host end: polls the status word and raises events
module hsw_host
  import hsw_pkg::*;
#(
  parameter logic [15:0] POLL_CYCLES = POLL_DIV
)
(
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // software port
  input  wire logic [3:0]       ADDR,
  input  wire logic [7:0]       WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [7:0]       RDATA,
  // interrupt
  output logic                  IRQ,
  // device link
  hsw_if.host                   LINK
);
  import hsw_pkg::*;
  logic [15:0]      div_q;
  logic             tick;
  logic             poll_q;
  logic             got_q;
  logic [1:0]       ctrl_q;
  logic [HSW_W-1:0] stat_q;
  logic [HSW_W-1:0] prev_q;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] en_q;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [7:0]       rdata_q;
  logic [7:0]       rsel;
  logic             wr_ctrl;

  // poll divider: one-cycle enable
  assign tick = (div_q == POLL_CYCLES - 16'h0001) && ctrl_q[CTRL_POLL_EN];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= tick || !ctrl_q[CTRL_POLL_EN] ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // init request driven from ctrl register
  assign LINK.init_req = ctrl_q[CTRL_INIT_REQ];
  assign LINK.rd_stb   = tick;
  assign wr_ctrl       = WR && (ADDR == ADDR_CTRL);

  // edges of busy, memory ready and inhibit let software wait before changes
  assign evt_set[EVT_IDLE]      = got_q & prev_q[BIT_CORE_BUSY] & ~LINK.rd_data[BIT_CORE_BUSY];
  assign evt_set[EVT_MEM_READY] = got_q & ~prev_q[BIT_MEM_READY] & LINK.rd_data[BIT_MEM_READY];
  assign evt_set[EVT_INH_RISE]  = got_q & ~prev_q[BIT_INHIBIT] & LINK.rd_data[BIT_INHIBIT];
  assign evt_set[EVT_INH_FALL]  = got_q & prev_q[BIT_INHIBIT] & ~LINK.rd_data[BIT_INHIBIT];
  assign evt_clr = (WR && ADDR == ADDR_EVT_CLR) ? WDATA[EVT_W-1:0] : '0;

  // poll capture and event flags; set beats clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      got_q  <= 1'b0;
      stat_q <= HSW_RESET;
      prev_q <= HSW_RESET;
      evt_q  <= '0;
      en_q   <= '0;
      ctrl_q <= 2'h0;
    end else begin
      got_q <= tick;
      if (got_q) begin
        stat_q <= LINK.rd_data;
        prev_q <= LINK.rd_data;
      end
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (WR && ADDR == ADDR_EVT_EN) en_q <= WDATA[EVT_W-1:0];
      if (wr_ctrl) ctrl_q <= WDATA[1:0];
    end
  end

  // software reads last polled flags at ADDR_STATUS; ADDR_SNAP returns only got_q
  // the status word is never written, only read
  assign rsel = (ADDR == ADDR_STATUS) ? stat_q :
                (ADDR == ADDR_CTRL)   ? {6'h00, ctrl_q} :
                (ADDR == ADDR_EVT)    ? {4'h0, evt_q} :
                (ADDR == ADDR_EVT_EN) ? {4'h0, en_q} :
                (ADDR == ADDR_SNAP)   ? {7'h00, got_q} : 8'h00;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= RD ? rsel : 8'h00;
    end
  end
  assign RDATA = rdata_q;
  assign IRQ   = |(evt_q & en_q);
endmodule

// *** rtl/hsw_pkg.sv ***
// How it works
// - bit7 high while write fifo full
// - bit6 high when write fifo empty
// - bit5 high when read fifo full
// - bit4 high when read fifo empty
// - bit3 high while any engine busy
// - host waits idle before mode change
// - host waits idle before text setting change
// - bit2 high when display memory ready
// - host requests memory init before polling
// - bit1 high during reset, init, power save
// - inhibit set when pll clock stops
// - bit0 mirrors interrupt output
// - status word is read only
// - host polls inhibit on power transitions
package hsw_pkg;
  localparam int          HSW_W          = 8;
  localparam int          BIT_WR_FULL    = 7;
  localparam int          BIT_WR_EMPTY   = 6;
  localparam int          BIT_RD_FULL    = 5;
  localparam int          BIT_RD_EMPTY   = 4;
  localparam int          BIT_CORE_BUSY  = 3;
  localparam int          BIT_MEM_READY  = 2;
  localparam int          BIT_INHIBIT    = 1;
  localparam int          BIT_IRQ        = 0;
  localparam logic [7:0]  HSW_RESET      = 8'h50;
  // host-side software port register offsets
  localparam logic [3:0]  ADDR_STATUS    = 4'h0;
  localparam logic [3:0]  ADDR_CTRL      = 4'h1;
  localparam logic [3:0]  ADDR_EVT       = 4'h2;
  localparam logic [3:0]  ADDR_EVT_CLR   = 4'h3;
  localparam logic [3:0]  ADDR_EVT_EN    = 4'h4;
  localparam logic [3:0]  ADDR_SNAP      = 4'h5;
  // ctrl bits and event bits
  localparam int          CTRL_POLL_EN   = 0;
  localparam int          CTRL_INIT_REQ  = 1;
  localparam int          EVT_W          = 4;
  localparam int          EVT_IDLE       = 0;
  localparam int          EVT_MEM_READY  = 1;
  localparam int          EVT_INH_RISE   = 2;
  localparam int          EVT_INH_FALL   = 3;
  localparam logic [15:0] POLL_DIV       = 16'h000A;
endpackage

// *** rtl/hsw_if.sv ***
// status read cycle between controller and host
interface hsw_if;
  import hsw_pkg::*;
  logic             rd_stb;
  logic [HSW_W-1:0] rd_data;
  logic             init_req;
  modport dev  (input rd_stb, input init_req, output rd_data);
  modport host (output rd_stb, output init_req, input rd_data);
endinterface

// *** rtl/hsw_device.sv ***
// status word end of the display controller
module hsw_device
  import hsw_pkg::*;
(
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // host link
  hsw_if.dev        LINK,
  // flag sources
  input  wire logic WR_FIFO_FULL,
  input  wire logic WR_FIFO_EMPTY,
  input  wire logic RD_FIFO_FULL,
  input  wire logic RD_FIFO_EMPTY,
  input  wire logic ENG_BUSY,
  input  wire logic MEM_READY,
  input  wire logic INT_RESET_RUN,
  input  wire logic INIT_DISP_RUN,
  input  wire logic PLL_STOPPED,
  input  wire logic IRQ_PIN,
  // memory init request seen from host
  output logic      MEM_INIT_REQ
);
  import hsw_pkg::*;
  logic [HSW_W-1:0] snap_d;
  logic [HSW_W-1:0] snap_q;
  logic [HSW_W-1:0] rdata_q;
  logic             init_q;

  assign snap_d[BIT_WR_FULL]   = WR_FIFO_FULL;
  assign snap_d[BIT_WR_EMPTY]  = WR_FIFO_EMPTY;
  assign snap_d[BIT_RD_FULL]   = RD_FIFO_FULL;
  assign snap_d[BIT_RD_EMPTY]  = RD_FIFO_EMPTY;
  assign snap_d[BIT_CORE_BUSY] = ENG_BUSY;
  assign snap_d[BIT_MEM_READY] = MEM_READY;
  // pll stop is the power save mark, not the mode request
  assign snap_d[BIT_INHIBIT]   = INT_RESET_RUN | INIT_DISP_RUN | PLL_STOPPED;
  assign snap_d[BIT_IRQ]       = IRQ_PIN;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      snap_q <= HSW_RESET;
    end else begin
      snap_q <= snap_d;
    end
  end

  // read only, no write path exists
  // read only copies the snapshot, no flag is touched
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= HSW_RESET;
      init_q  <= 1'b0;
    end else begin
      init_q <= LINK.init_req;
      if (LINK.rd_stb) begin
        rdata_q <= snap_q;
      end
    end
  end

  assign LINK.rd_data = rdata_q;
  assign MEM_INIT_REQ = init_q;
endmodule

// *** tb/hsw_status_sva.sv ***
module hsw_status_sva (
  // clock, reset, link, flag sources
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic       WR_FIFO_FULL,
  input wire logic       WR_FIFO_EMPTY,
  input wire logic       RD_FIFO_FULL,
  input wire logic       RD_FIFO_EMPTY,
  input wire logic       ENG_BUSY,
  input wire logic       MEM_READY,
  input wire logic       INT_RESET_RUN,
  input wire logic       INIT_DISP_RUN,
  input wire logic       PLL_STOPPED,
  input wire logic       IRQ_PIN
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // answer lands a cycle after the strobe, flags are two edges old by then
  sequence s_poll; rd_stb ##1 1'b1; endsequence
  a_wr_full: assert property (s_poll |-> rd_data[7] == $past(WR_FIFO_FULL, 2)) else $error("bit 7 wrong");
  a_wr_empty: assert property (s_poll |-> rd_data[6] == $past(WR_FIFO_EMPTY, 2)) else $error("bit 6 wrong");
  a_rd_full: assert property (s_poll |-> rd_data[5] == $past(RD_FIFO_FULL, 2)) else $error("bit 5 wrong");
  a_rd_empty: assert property (s_poll |-> rd_data[4] == $past(RD_FIFO_EMPTY, 2)) else $error("bit 4 wrong");
  a_core_busy: assert property (s_poll |-> rd_data[3] == $past(ENG_BUSY, 2)) else $error("bit 3 wrong");
  a_mem_ready: assert property (s_poll |-> rd_data[2] == $past(MEM_READY, 2)) else $error("bit 2 wrong");
  a_inhibit_or: assert property (
    s_poll |-> rd_data[1] == ($past(INT_RESET_RUN, 2) | $past(INIT_DISP_RUN, 2) | $past(PLL_STOPPED, 2)))
    else $error("bit 1 wrong");
  a_irq_mirror: assert property (s_poll |-> rd_data[0] == $past(IRQ_PIN, 2)) else $error("bit 0 wrong");
  // the word only moves on a poll, never on its own
  a_data_holds: assert property (!rd_stb |=> $stable(rd_data)) else $error("status word moved unpolled");
endmodule

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hsw_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  src = '0;
  logic [3:0]  addr = '0;
  logic [7:0]  wdata = '0;
  logic        wr = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic        init_seen;
  logic [15:0] lfsr_q = 16'h3359;
  int          num_errors = 0;
  int          checked = 0;
  hsw_if link ();
  // 10 MHz clock
  always #50 clk = ~clk;
  // both ends joined, flags from src
  hsw_device i_hsw_device (.CLK(clk), .RST_N(rst_n), .LINK(link), .WR_FIFO_FULL(src[9]), .WR_FIFO_EMPTY(src[8]),
    .RD_FIFO_FULL(src[7]), .RD_FIFO_EMPTY(src[6]), .ENG_BUSY(src[5]), .MEM_READY(src[4]), .INT_RESET_RUN(src[3]),
    .INIT_DISP_RUN(src[2]), .PLL_STOPPED(src[1]), .IRQ_PIN(src[0]), .MEM_INIT_REQ(init_seen));
  hsw_host #(.POLL_CYCLES(16'h0002)) i_hsw_host (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd_s), .RDATA(rdata), .IRQ(irq), .LINK(link));
  hsw_status_sva i_hsw_status_sva (.CLK(clk), .RST_N(rst_n), .rd_stb(link.rd_stb), .rd_data(link.rd_data),
    .WR_FIFO_FULL(src[9]), .WR_FIFO_EMPTY(src[8]), .RD_FIFO_FULL(src[7]), .RD_FIFO_EMPTY(src[6]),
    .ENG_BUSY(src[5]), .MEM_READY(src[4]), .INT_RESET_RUN(src[3]), .INIT_DISP_RUN(src[2]),
    .PLL_STOPPED(src[1]), .IRQ_PIN(src[0]));
  // stimulus source and expected word
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] exp_word(input logic [9:0] s);
    return {s[9:4], |s[3:1], s[0]};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // single pin levels, irq and init request
  task automatic chk_pin(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // bus cycles end 1 ns after the edge so follow-up checks see settled values
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {addr, rd_s} <= {a, 1'b1};
    @(posedge clk) rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #200000 num_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(link.rd_data, 8'h50);
    wr_reg(ADDR_CTRL, 8'h03);
    #300 chk({7'h00, init_seen}, 8'h01);
    // corners first, then random flags; status writes must be ignored
    for (int i = 0; i < 24; i++) begin
      lfsr_q = lfsr(lfsr_q);
      @(posedge clk) src <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : lfsr_q[9:0];
      wr_reg(ADDR_STATUS, 8'hFF);
      #900 rd_reg(ADDR_STATUS, exp_word(src));
    end
    // busy falling edge raises a masked, then enabled, then cleared event
    @(posedge clk) src <= 10'h000;
    repeat (9) @(posedge clk);
    wr_reg(ADDR_EVT_EN, 8'h00);
    wr_reg(ADDR_EVT_CLR, 8'h0F);
    @(posedge clk) src <= 10'h020;
    repeat (9) @(posedge clk);
    src <= 10'h000;
    repeat (9) @(posedge clk);
    rd_reg(ADDR_EVT, 8'h01);
    chk_pin(irq, 1'b0);
    wr_reg(ADDR_EVT_EN, 8'h01);
    chk_pin(irq, 1'b1);
    wr_reg(ADDR_EVT_CLR, 8'h01);
    chk_pin(irq, 1'b0);
    // memory ready and inhibit rise together, then inhibit falls alone
    @(posedge clk) src <= 10'h012;
    repeat (9) @(posedge clk);
    src <= 10'h010;
    repeat (9) @(posedge clk);
    rd_reg(ADDR_EVT, 8'h0E);
    rd_reg(ADDR_CTRL, 8'h03);
    rd_reg(4'hF, 8'h00);
    // mid-run reset; with polling off a status write has nothing to hide behind
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(link.rd_data, 8'h50);
    chk_pin(init_seen, 1'b0);
    rd_reg(ADDR_EVT, 8'h00);
    wr_reg(ADDR_STATUS, 8'hFF);
    rd_reg(ADDR_STATUS, 8'h50);
    rd_reg(ADDR_SNAP, 8'h00);
    wrap_up();
  end
endmodule
